// ===== design/flash_host_pkg.sv
// Constants and types shared by the flash host controller files
package flash_host_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;

  // ----------------------------------------------------------------
  // Bus cycle timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int SETUP_NS = 20;
  localparam int STROBE_NS = 70;
  localparam int HOLD_NS = 20;
  localparam logic [2:0] SETUP_CYC = 3'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] STROBE_CYC = 3'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] HOLD_CYC = 3'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_WRITE_SETUP = 8'h40;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESUME = 8'hD0;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_BLOCK_LOCK = 8'h01;
  localparam logic [7:0] CMD_PERM_LOCK = 8'hF1;
  localparam logic [7:0] CMD_CLEAR_LOCKS = 8'hD0;
  localparam logic [7:0] CMD_OTP_SETUP = 8'hC0;

  // ----------------------------------------------------------------
  // Status bit positions and reset values
  // ----------------------------------------------------------------
  localparam int READY_BIT = 7;
  localparam int ERASE_CLEAR_ERR_BIT = 5;
  localparam int WRITE_ERR_BIT = 4;
  localparam int SUPPLY_ERR_BIT = 3;
  localparam int SUSPENDED_BIT = 2;
  localparam int PROTECT_ERR_BIT = 1;
  localparam logic [7:0] ERR_MASK = 8'h3A;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

  // ----------------------------------------------------------------
  // User operations
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_READ_STATUS,
    OP_CLEAR_STATUS,
    OP_WRITE,
    OP_SUSPEND,
    OP_RESUME,
    OP_READ,
    OP_SET_BLOCK_LOCK,
    OP_SET_PERM_LOCK,
    OP_CLEAR_LOCKS,
    OP_OTP
  } op_type;

endpackage

// ===== design/bus_cycle_if.sv
// Request and answer of one flash bus cycle between controller and cycle engine
`timescale 1ns/100ps
interface bus_cycle_if;
  logic req;
  logic wr;
  logic [flash_host_pkg::ADDR_W-1:0] addr;
  logic [flash_host_pkg::DATA_W-1:0] wdata;
  logic done;
  logic [flash_host_pkg::DATA_W-1:0] rdata;

  modport ctrl (output req, output wr, output addr, output wdata, input done, input rdata);
  modport engine (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

// ===== design/flash_bus_cycle.sv
// Single read or write cycle on the flash pins
`timescale 1ns/100ps
module flash_bus_cycle (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  // Controller side
  bus_cycle_if.engine cyc,
  // Flash pins
  output logic ce_n_o,
  output logic we_n_o,
  output logic oe_n_o,
  output logic [flash_host_pkg::ADDR_W-1:0] addr_o,
  output logic [flash_host_pkg::DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  input wire logic [flash_host_pkg::DATA_W-1:0] dq_i
);

  typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD} estate_type;

  estate_type state_reg, state_next;
  logic [2:0] cnt_reg, cnt_next;
  logic wr_reg, wr_next;
  logic ce_n_reg, ce_n_next, we_n_reg, we_n_next, oe_n_reg, oe_n_next;
  logic oe_reg, oe_next, done_reg, done_next;
  logic [flash_host_pkg::ADDR_W-1:0] addr_reg, addr_next;
  logic [flash_host_pkg::DATA_W-1:0] dq_reg, dq_next, rdata_reg, rdata_next;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    wr_next = wr_reg;
    ce_n_next = ce_n_reg;
    we_n_next = we_n_reg;
    oe_n_next = oe_n_reg;
    oe_next = oe_reg;
    done_next = 1'b0;
    addr_next = addr_reg;
    dq_next = dq_reg;
    rdata_next = rdata_reg;
    unique case (state_reg)
      E_IDLE: begin
        if (cyc.req) begin
          wr_next = cyc.wr;
          addr_next = cyc.addr;
          dq_next = cyc.wdata;
          ce_n_next = 1'b0;
          oe_next = cyc.wr;
          cnt_next = flash_host_pkg::SETUP_CYC - 3'h1;
          state_next = E_SETUP;
        end
      end
      E_SETUP: begin
        if (cnt_reg == 3'h0) begin
          we_n_next = ~wr_reg;
          oe_n_next = wr_reg;
          cnt_next = flash_host_pkg::STROBE_CYC - 3'h1;
          state_next = E_STROBE;
        end else begin
          cnt_next = cnt_reg - 3'h1;
        end
      end
      E_STROBE: begin
        if (cnt_reg == 3'h0) begin
          if (!wr_reg) begin
            rdata_next = dq_i;
          end
          we_n_next = 1'b1;
          oe_n_next = 1'b1;
          cnt_next = flash_host_pkg::HOLD_CYC - 3'h1;
          state_next = E_HOLD;
        end else begin
          cnt_next = cnt_reg - 3'h1;
        end
      end
      E_HOLD: begin
        if (cnt_reg == 3'h0) begin
          ce_n_next = 1'b1;
          oe_next = 1'b0;
          done_next = 1'b1;
          state_next = E_IDLE;
        end else begin
          cnt_next = cnt_reg - 3'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= E_IDLE;
      cnt_reg <= 3'h0;
      wr_reg <= 1'b0;
      ce_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      oe_reg <= 1'b0;
      done_reg <= 1'b0;
      addr_reg <= '0;
      dq_reg <= flash_host_pkg::DATA_RST;
      rdata_reg <= flash_host_pkg::DATA_RST;
    end else if (en_i) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      wr_reg <= wr_next;
      ce_n_reg <= ce_n_next;
      we_n_reg <= we_n_next;
      oe_n_reg <= oe_n_next;
      oe_reg <= oe_next;
      done_reg <= done_next;
      addr_reg <= addr_next;
      dq_reg <= dq_next;
      rdata_reg <= rdata_next;
    end
  end

  assign ce_n_o = ce_n_reg;
  assign we_n_o = we_n_reg;
  assign oe_n_o = oe_n_reg;
  assign addr_o = addr_reg;
  assign dq_o = dq_reg;
  assign dq_oe_o = oe_reg;
  assign cyc.done = done_reg;
  assign cyc.rdata = rdata_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  AST_STROBE_WIDTH: assert property ($fell(we_n_o) && en_i |-> (!we_n_o && en_i)[*3])
    else $error("write strobe shorter than three cycles");

  AST_SELECT_FRAMES_STROBE: assert property ((!we_n_o || !oe_n_o) |-> !ce_n_o)
    else $error("strobe active while chip deselected");

  AST_NO_CONTENTION: assert property (!oe_n_o |-> !dq_oe_o && we_n_o)
    else $error("host drives data while device outputs enabled");

endmodule // flash_bus_cycle

// ===== design/flash_host_ctrl.sv
// Host controller sequencing flash commands and status polling
`timescale 1ns/100ps
module flash_host_ctrl (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  input wire logic power_ok_i,
  // User orders
  input wire logic start_i,
  input wire logic [3:0] op_i,
  input wire logic [flash_host_pkg::ADDR_W-1:0] addr_i,
  input wire logic [flash_host_pkg::DATA_W-1:0] wdata_i,
  // User results
  output logic busy_o,
  output logic done_o,
  output logic [flash_host_pkg::DATA_W-1:0] rdata_o,
  output logic [7:0] status_o,
  output logic error_o,
  output logic seq_error_o,
  output logic suspended_o,
  // Flash pins
  output logic ce_n_o,
  output logic we_n_o,
  output logic oe_n_o,
  output logic rp_n_o,
  output logic [flash_host_pkg::ADDR_W-1:0] addr_o,
  output logic [flash_host_pkg::DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  input wire logic [flash_host_pkg::DATA_W-1:0] dq_i
);

  typedef enum logic [3:0] {
    S_IDLE, S_CLEAR, S_FIRST, S_SECOND, S_STAT_CMD, S_STAT_RD, S_ARRAY, S_DATA_RD, S_DONE
  } state_type;

  bus_cycle_if cyc ();

  flash_bus_cycle u_cycle (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .en_i(en_i),
    .cyc(cyc.engine),
    .ce_n_o(ce_n_o),
    .we_n_o(we_n_o),
    .oe_n_o(oe_n_o),
    .addr_o(addr_o),
    .dq_o(dq_o),
    .dq_oe_o(dq_oe_o),
    .dq_i(dq_i)
  );

  state_type state_reg, state_next, after_reg, after_next;
  flash_host_pkg::op_type op_reg, op_next;
  logic issued_reg, issued_next, req_reg, req_next, wr_reg, wr_next;
  logic busy_reg, busy_next, done_reg, done_next, err_pend_reg, err_pend_next;
  logic susp_reg, susp_next, seq_reg, seq_next;
  logic [flash_host_pkg::ADDR_W-1:0] addr_reg, addr_next;
  logic [flash_host_pkg::DATA_W-1:0] wdata_reg, wdata_next, user_data_reg, user_data_next;
  logic [flash_host_pkg::DATA_W-1:0] rdata_reg, rdata_next;
  logic [7:0] status_reg, status_next;
  logic rp_n_reg, rp_n_next;
  logic [7:0] code1, code2, send;
  logic has2, data2, poll, arr, is_wr, go;
  state_type nxt;

  // ----------------------------------------------------------------
  // Operation decode
  // ----------------------------------------------------------------
  always_comb begin
    code1 = flash_host_pkg::CMD_READ_STATUS;
    code2 = flash_host_pkg::CMD_READ_STATUS;
    has2 = 1'b0;
    data2 = 1'b0;
    poll = 1'b0;
    arr = 1'b0;
    unique case (op_reg)
      flash_host_pkg::OP_READ_STATUS: begin
        poll = 1'b1;
      end
      flash_host_pkg::OP_CLEAR_STATUS: begin
        code1 = flash_host_pkg::CMD_CLEAR_STATUS;
      end
      flash_host_pkg::OP_WRITE: begin
        code1 = flash_host_pkg::CMD_WRITE_SETUP;
        has2 = 1'b1;
        data2 = 1'b1;
        poll = 1'b1;
      end
      flash_host_pkg::OP_SUSPEND: begin
        code1 = flash_host_pkg::CMD_SUSPEND;
        poll = 1'b1;
      end
      flash_host_pkg::OP_RESUME: begin
        code1 = flash_host_pkg::CMD_RESUME;
      end
      flash_host_pkg::OP_READ: begin
        code1 = flash_host_pkg::CMD_READ_ARRAY;
      end
      flash_host_pkg::OP_SET_BLOCK_LOCK: begin
        code1 = flash_host_pkg::CMD_LOCK_SETUP;
        code2 = flash_host_pkg::CMD_BLOCK_LOCK;
        has2 = 1'b1;
        poll = 1'b1;
      end
      flash_host_pkg::OP_SET_PERM_LOCK: begin
        code1 = flash_host_pkg::CMD_LOCK_SETUP;
        code2 = flash_host_pkg::CMD_PERM_LOCK;
        has2 = 1'b1;
        poll = 1'b1;
      end
      flash_host_pkg::OP_CLEAR_LOCKS: begin
        code1 = flash_host_pkg::CMD_LOCK_SETUP;
        code2 = flash_host_pkg::CMD_CLEAR_LOCKS;
        has2 = 1'b1;
        poll = 1'b1;
        arr = 1'b1;
      end
      flash_host_pkg::OP_OTP: begin
        code1 = flash_host_pkg::CMD_OTP_SETUP;
        has2 = 1'b1;
        data2 = 1'b1;
        poll = 1'b1;
      end
      default: begin
        poll = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    after_next = after_reg;
    op_next = op_reg;
    issued_next = issued_reg;
    req_next = 1'b0;
    wr_next = wr_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    err_pend_next = err_pend_reg;
    susp_next = susp_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    user_data_next = user_data_reg;
    rdata_next = rdata_reg;
    status_next = status_reg;
    go = 1'b1;
    is_wr = 1'b1;
    send = flash_host_pkg::CMD_READ_STATUS;
    nxt = S_DONE;
    unique case (state_reg)
      S_IDLE: begin
        go = 1'b0;
        if (start_i) begin
          op_next = flash_host_pkg::op_type'(op_i);
          addr_next = addr_i;
          user_data_next = wdata_i;
          busy_next = 1'b1;
          // clear stale errors before a retry
          if (err_pend_reg && op_i != flash_host_pkg::OP_CLEAR_STATUS) begin
            state_next = S_CLEAR;
          end else begin
            state_next = S_FIRST;
          end
        end
      end
      S_CLEAR: begin
        send = flash_host_pkg::CMD_CLEAR_STATUS;
        nxt = S_FIRST;
      end
      S_FIRST: begin
        send = code1;
        if (op_reg == flash_host_pkg::OP_READ) begin
          nxt = S_DATA_RD;
        end else if (has2) begin
          nxt = S_SECOND;
        end else if (poll) begin
          nxt = S_STAT_CMD;
        end
      end
      S_SECOND: begin
        send = code2;
        nxt = S_STAT_CMD;
      end
      S_STAT_CMD: begin
        nxt = S_STAT_RD;
      end
      S_STAT_RD: begin
        is_wr = 1'b0;
        nxt = S_STAT_RD;
        if (start_i && op_i == flash_host_pkg::OP_SUSPEND &&
            op_reg == flash_host_pkg::OP_WRITE) begin
          op_next = flash_host_pkg::OP_SUSPEND;
          after_next = S_FIRST;
        end
      end
      S_ARRAY: begin
        send = flash_host_pkg::CMD_READ_ARRAY;
      end
      S_DATA_RD: begin
        is_wr = 1'b0;
      end
      S_DONE: begin
        go = 1'b0;
        busy_next = 1'b0;
        after_next = S_IDLE;
        done_next = 1'b1;
        state_next = S_IDLE;
      end
    endcase
    if (go) begin
      if (!issued_reg) begin
        req_next = 1'b1;
        issued_next = 1'b1;
        wr_next = is_wr;
        wdata_next = {8'h00, send};
        if (state_reg == S_SECOND && data2) begin
          wdata_next = user_data_reg;
        end
      end else if (cyc.done) begin
        issued_next = 1'b0;
        state_next = nxt;
        if (state_reg == S_CLEAR || op_reg == flash_host_pkg::OP_CLEAR_STATUS) begin
          err_pend_next = 1'b0;
          status_next = status_reg & ~flash_host_pkg::ERR_MASK;
        end
        if (state_reg == S_DATA_RD) begin
          rdata_next = cyc.rdata;
        end
        // send suspend once a busy status read ends
        if (state_reg == S_STAT_RD && after_reg == S_FIRST) begin
          state_next = S_FIRST;
          after_next = S_IDLE;
        end
        // busy reads carry only the ready bit
        if (state_reg == S_STAT_RD && cyc.rdata[flash_host_pkg::READY_BIT]) begin
          // sticky flags kept as read back
          status_next = cyc.rdata[7:0];
          err_pend_next = |(cyc.rdata[7:0] & flash_host_pkg::ERR_MASK);
          susp_next = (op_reg == flash_host_pkg::OP_SUSPEND) &&
                      cyc.rdata[flash_host_pkg::SUSPENDED_BIT];
          state_next = arr ? S_ARRAY : S_DONE;
        end
      end
    end
    if (op_reg == flash_host_pkg::OP_RESUME && state_reg == S_DONE) begin
      susp_next = 1'b0;
    end
    // reset pin low wipes device status
    if (!rp_n_reg) begin
      status_next = flash_host_pkg::STATUS_RST;
      err_pend_next = 1'b0;
      susp_next = 1'b0;
    end
    seq_next = status_next[flash_host_pkg::ERASE_CLEAR_ERR_BIT] &
               status_next[flash_host_pkg::WRITE_ERR_BIT];
  end

  assign rp_n_next = power_ok_i;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= S_IDLE;
      after_reg <= S_IDLE;
      op_reg <= flash_host_pkg::OP_READ_STATUS;
      issued_reg <= 1'b0;
      req_reg <= 1'b0;
      wr_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      err_pend_reg <= 1'b0;
      susp_reg <= 1'b0;
      seq_reg <= 1'b0;
      addr_reg <= '0;
      wdata_reg <= flash_host_pkg::DATA_RST;
      user_data_reg <= flash_host_pkg::DATA_RST;
      rdata_reg <= flash_host_pkg::DATA_RST;
      status_reg <= flash_host_pkg::STATUS_RST;
      rp_n_reg <= 1'b0;
    end else if (en_i) begin
      state_reg <= state_next;
      after_reg <= after_next;
      op_reg <= op_next;
      issued_reg <= issued_next;
      req_reg <= req_next;
      wr_reg <= wr_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
      err_pend_reg <= err_pend_next;
      susp_reg <= susp_next;
      seq_reg <= seq_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      user_data_reg <= user_data_next;
      rdata_reg <= rdata_next;
      status_reg <= status_next;
      rp_n_reg <= rp_n_next;
    end
  end

  assign cyc.req = req_reg;
  assign cyc.wr = wr_reg;
  assign cyc.addr = addr_reg;
  assign cyc.wdata = wdata_reg;
  assign busy_o = busy_reg;
  assign done_o = done_reg;
  assign rdata_o = rdata_reg;
  assign status_o = status_reg;
  assign error_o = err_pend_reg;
  // both flags mean bad command sequence
  assign seq_error_o = seq_reg;
  assign suspended_o = susp_reg;
  assign rp_n_o = rp_n_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  AST_RESET_PIN_FOLLOWS: assert property (en_i |=> rp_n_o == $past(power_ok_i))
    else $error("reset pin does not follow power-good");

  AST_POLL_READY: assert property ($rose(done_o) && poll |-> status_o[7] || !rp_n_o)
    else $error("polled operation finished without ready status");

  AST_BUSY_IGNORED: assert property (
    state_reg == S_STAT_RD && cyc.done && !cyc.rdata[7] && en_i && after_reg != S_FIRST
    |=> state_reg == S_STAT_RD && status_o == $past(status_o))
    else $error("busy status read was acted on");

  AST_SUSPEND_REDIRECT: assert property (
    state_reg == S_STAT_RD && cyc.done && !cyc.rdata[7] && en_i && after_reg == S_FIRST
    |=> state_reg == S_FIRST && op_reg == flash_host_pkg::OP_SUSPEND)
    else $error("suspend request not sent after busy read");

  AST_CLEAR_FIRST: assert property (
    state_reg == S_IDLE && start_i && en_i && err_pend_reg &&
    op_i != 4'h1 && rp_n_o |=> state_reg == S_CLEAR)
    else $error("retry started without clearing status");

  AST_WRITE_SETUP: assert property (
    req_reg && state_reg == S_FIRST &&
    op_reg == flash_host_pkg::OP_WRITE |-> wdata_reg[7:0] == 8'h40)
    else $error("write not preceded by setup code");

  AST_PERM_CONFIRM: assert property (
    req_reg && state_reg == S_SECOND &&
    op_reg == flash_host_pkg::OP_SET_PERM_LOCK |-> wdata_reg[7:0] == 8'hF1)
    else $error("permanent lock confirm code wrong");

  AST_OTP_SETUP: assert property (
    req_reg && state_reg == S_FIRST &&
    op_reg == flash_host_pkg::OP_OTP |-> wdata_reg[7:0] == 8'hC0)
    else $error("OTP program not preceded by setup code");

  AST_LOCKS_TO_ARRAY: assert property (
    state_reg == S_STAT_RD && cyc.done && cyc.rdata[7] &&
    en_i && op_reg == flash_host_pkg::OP_CLEAR_LOCKS |=> state_reg == S_ARRAY)
    else $error("clear locks did not return to array mode");

  AST_STICKY_ERR: assert property (
    err_pend_reg && rp_n_o && state_reg == S_IDLE && !start_i
    |=> err_pend_reg)
    else $error("error flag dropped without clear-status");

  AST_STATUS_WIPE: assert property (!rp_n_o && en_i |=> status_o == 8'h00)
    else $error("status kept while reset pin low");

  COV_WRITE: cover property ($rose(done_o) && op_reg == flash_host_pkg::OP_WRITE);
  COV_SUSPENDED: cover property ($rose(suspended_o));
  COV_CLEAR_LOCKS: cover property ($rose(done_o) && op_reg == flash_host_pkg::OP_CLEAR_LOCKS);
  COV_AUTO_CLEAR: cover property (state_reg == S_CLEAR);

endmodule // flash_host_ctrl

// ===== tb/flash_dev_model.sv
// Behavioural flash device answering the controller's bus cycles
`timescale 1ns/100ps
module flash_dev_model (
  // Clock and reset pin
  input wire logic clk_i,
  input wire logic rp_n_i,
  // Bus pins
  input wire logic ce_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic [18:0] addr_i,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  // Test knobs
  input wire logic [7:0] fault_i,
  input wire logic [7:0] wait_i
);
  logic [7:0] sr_reg;
  logic [2:0] mode_reg;
  logic [8:0] cnt_reg;
  logic sus_reg, perm_reg, we_q_reg, rd;
  logic [15:0] mem_reg [0:15];
  logic [15:0] last_reg, val;
  logic [7:0] c;
  assign c = dq_i[7:0];
  assign val = (mode_reg == 3'h1) ? {8'h00, sr_reg[7], sr_reg[7] ? sr_reg[6:0] : ~sr_reg[6:0]}
    : mem_reg[addr_i[3:0]];
  assign rd = !ce_n_i && !oe_n_i;
  assign dq_o = rd ? val : ~last_reg;
  task automatic go();
    sr_reg[7] <= 1'b0;
    cnt_reg <= {1'b0, wait_i} + 9'h1;
    mode_reg <= 3'h1;
  endtask
  always @(posedge clk_i or negedge rp_n_i) begin
    if (!rp_n_i) begin
      sr_reg <= 8'h80;
      mode_reg <= 3'h0;
      cnt_reg <= 9'h0;
      sus_reg <= 1'b0;
      we_q_reg <= 1'b1;
      last_reg <= 16'h0000;
    end else begin
      we_q_reg <= we_n_i;
      if (rd)
        last_reg <= val;
      if (cnt_reg != 9'h0 && !sus_reg) begin
        cnt_reg <= cnt_reg - 9'h1;
        if (cnt_reg == 9'h1)
          sr_reg <= sr_reg | 8'h80 | (fault_i & 8'h3A);
      end
      if (we_n_i && !we_q_reg && !ce_n_i) begin
        if (mode_reg == 3'h2 || mode_reg == 3'h4) begin
          mem_reg[addr_i[3:0]] <= dq_i;
          go();
        end else if (mode_reg == 3'h3) begin
          go();
          if (c == 8'hF1)
            perm_reg <= 1'b1;
          if ((c == 8'h01 || c == 8'hD0) && perm_reg)
            sr_reg[1] <= 1'b1;
          if (c != 8'h01 && c != 8'hF1 && c != 8'hD0)
            sr_reg[5:4] <= 2'b11;
        end else begin
          case (c)
            8'h70: mode_reg <= 3'h1;
            8'h50: sr_reg <= sr_reg & ~8'h3A;
            8'h40, 8'h10: mode_reg <= 3'h2;
            8'h60: mode_reg <= 3'h3;
            8'hC0: mode_reg <= 3'h4;
            8'hB0: begin
              mode_reg <= 3'h1;
              sus_reg <= cnt_reg != 9'h0;
              sr_reg[2] <= cnt_reg != 9'h0;
              sr_reg[7] <= 1'b1;
            end
            8'hD0: begin
              sus_reg <= 1'b0;
              sr_reg[2] <= 1'b0;
              sr_reg[7] <= !(sus_reg && cnt_reg != 9'h0);
              mode_reg <= 3'h1;
            end
            default: mode_reg <= 3'h0;
          endcase
        end
      end
    end
  end
  initial perm_reg = 1'b0;
endmodule // flash_dev_model

// ===== tb/flash_host_ctrl_tb_top.sv
// Testbench for the flash host controller against the device model
`timescale 1ns/100ps
module flash_host_ctrl_tb_top;
  logic clk_i, nrst_i, power_ok_i, start_i;
  logic busy_o, done_o, error_o, seq_error_o, suspended_o;
  logic ce_n_o, we_n_o, oe_n_o, rp_n_o, dq_oe_o;
  logic [3:0] op_i;
  logic [18:0] addr_i, addr_o;
  logic [15:0] wdata_i, rdata_o, dq_o, dev_dq, bus;
  logic [7:0] status_o, fault, wt;
  int n_mismatch = 0;
  int n_tests = 0;
  assign bus = dq_oe_o ? dq_o : dev_dq;
  flash_host_ctrl flash_host_ctrl_inst (.clk_i, .nrst_i, .en_i(1'b1), .power_ok_i, .start_i,
    .op_i, .addr_i, .wdata_i, .busy_o, .done_o, .rdata_o, .status_o, .error_o, .seq_error_o,
    .suspended_o, .ce_n_o, .we_n_o, .oe_n_o, .rp_n_o, .addr_o, .dq_o, .dq_oe_o, .dq_i(bus));
  flash_dev_model flash_dev_model_inst (.clk_i, .rp_n_i(rp_n_o), .ce_n_i(ce_n_o),
    .we_n_i(we_n_o), .oe_n_i(oe_n_o), .addr_i(addr_o), .dq_i(bus), .dq_o(dev_dq),
    .fault_i(fault), .wait_i(wt));
  task automatic end_of_test();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // Read ops take d as the expected array data
  task automatic run(input logic [3:0] o, input logic [3:0] a, input logic [15:0] d,
      input logic [7:0] f, input logic [7:0] esr);
    int k;
    fault <= f;
    op_i <= o;
    addr_i <= {15'h0000, a};
    wdata_i <= d;
    start_i <= 1'b1;
    @(posedge clk_i);
    start_i <= 1'b0;
    k = 0;
    do begin
      @(posedge clk_i);
      #1;
      k++;
    end while (done_o !== 1'b1 && k < 8000);
    if (k >= 8000) begin
      n_mismatch++;
      $display("unexpected at %0t: no done", $time);
    end
    check({8'h00, status_o}, {8'h00, esr});
    check(16'(error_o), 16'(|(esr & 8'h3A)));
    check(16'(seq_error_o), 16'(&esr[5:4]));
    check(16'(busy_o), 16'h0000);
    if (o == 4'h5)
      check(rdata_o, d);
    @(posedge clk_i);
  endtask
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    #2000000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    {nrst_i, start_i, op_i, addr_i, wdata_i, fault, wt} = '0;
    power_ok_i = 1'b1;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    run(4'h0, 4'h0, 16'h0000, 8'h00, 8'h80);
    wt <= 8'hC8;
    run(4'h2, 4'h5, 16'h1234, 8'h00, 8'h80);
    wt <= 8'h00;
    run(4'h5, 4'h5, 16'h1234, 8'h00, 8'h80);
    run(4'h9, 4'h6, 16'hABCD, 8'h00, 8'h80);
    run(4'h5, 4'h6, 16'hABCD, 8'h00, 8'h80);
    run(4'h2, 4'h7, 16'h5555, 8'h18, 8'h98);
    repeat (4) @(posedge clk_i);
    check(16'(error_o), 16'h0001);
    run(4'h1, 4'h0, 16'h0000, 8'h00, 8'h80);
    run(4'h3, 4'h0, 16'h0000, 8'h00, 8'h80);
    check(16'(suspended_o), 16'h0000);
    run(4'h4, 4'h0, 16'h0000, 8'h00, 8'h80);
    wt <= 8'hC8;
    op_i <= 4'h2;
    addr_i <= 19'h00008;
    wdata_i <= 16'h0F0F;
    start_i <= 1'b1;
    @(posedge clk_i);
    start_i <= 1'b0;
    repeat (40) @(posedge clk_i);
    check(16'(busy_o), 16'h0001);
    run(4'h3, 4'h0, 16'h0000, 8'h00, 8'h84);
    check(16'(suspended_o), 16'h0001);
    wt <= 8'h00;
    run(4'h5, 4'h5, 16'h1234, 8'h00, 8'h84);
    run(4'h4, 4'h0, 16'h0000, 8'h00, 8'h84);
    check(16'(suspended_o), 16'h0000);
    run(4'h0, 4'h0, 16'h0000, 8'h00, 8'h80);
    run(4'h6, 4'h2, 16'h0000, 8'h30, 8'hB0);
    run(4'h6, 4'h3, 16'h0000, 8'h10, 8'h90);
    run(4'h8, 4'h0, 16'h0000, 8'h20, 8'hA0);
    run(4'h1, 4'h0, 16'h0000, 8'h00, 8'h80);
    run(4'h7, 4'h0, 16'h0000, 8'h00, 8'h80);
    run(4'h6, 4'h4, 16'h0000, 8'h00, 8'h82);
    run(4'h8, 4'h0, 16'h0000, 8'h00, 8'h82);
    run(4'h1, 4'h0, 16'h0000, 8'h00, 8'h80);
    power_ok_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    check(16'(rp_n_o), 16'h0000);
    check({8'h00, status_o}, 16'h0000);
    @(posedge clk_i);
    power_ok_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    run(4'h0, 4'h0, 16'h0000, 8'h00, 8'h80);
    end_of_test();
  end
endmodule // flash_host_ctrl_tb_top
